//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic        clk_in = 1'b0;
   logic        srst_in = 1'b1;
   logic        sub_clk_in = 1'b0;
   logic [2:0]  power_mode_in = 3'h5;   // Standby keeps the counter parked
   logic        msb_in = 1'b0;          // Module standby request
   wire  logic [4:0]  adr_w;
   wire  logic        rd_w, wr_w, wait_w, tog_h, tog_l, irq;
   wire  logic [31:0] wd_w, q_w;
   wire  logic [3:0]  be_w;
   int          n_fail = 0;
   int          n_checks = 0;
   int          n_sub = 0;              // Subclock rising edges seen
   int          ch, cl, fh, fl, e0, i;
   logic [31:0] q, c0;
   logic        ph, pl;

   tfm_top dut_u (.clk_in(clk_in), .srst_in(srst_in), .avs_address_in(adr_w),
      .avs_read_in(rd_w), .avs_write_in(wr_w), .avs_writedata_in(wd_w),
      .avs_byteenable_in(be_w), .avs_readdata_out(q_w), .avs_waitrequest_out(wait_w),
      .sub_clk_in(sub_clk_in), .power_mode_in(power_mode_in), .module_standby_in(msb_in),
      .toggle_out_upper_out(tog_h), .toggle_out_lower_out(tog_l), .irq_out(irq));
   tfm_cpu_model cpu_u (.clk_in(clk_in), .waitrequest_in(wait_w), .readdata_in(q_w),
      .address_out(adr_w), .read_out(rd_w), .write_out(wr_w), .writedata_out(wd_w),
      .byteenable_out(be_w));

   // ****************************************
   // Clocks; subclock offset so it never lands on a system edge
   // ****************************************
   initial
      forever #4 clk_in = ~clk_in;
   initial
   begin
      #0.05;
      forever #48.1 sub_clk_in = ~sub_clk_in;
   end
   always @(posedge sub_clk_in)
      n_sub++;

   // ****************************************
   // Bus helpers and comparisons
   // ****************************************
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      cpu_u.xfer(1'b0, a, d, x);
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      cpu_u.xfer(1'b1, a, 32'h0, v);
   endtask : rd
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_pin(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch t=%0t pin got %b exp %b", $time, got, exp);
      end
   endtask : chk_pin
   task automatic chk_rng(input logic signed [31:0] got, input int lo, input int hi);
      n_checks++;
      if ($isunknown(got) || got < lo || got > hi)
      begin
         n_fail++;
         $display("mismatch t=%0t count %0d not in %0d..%0d", $time, got, lo, hi);
      end
   endtask : chk_rng
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize

   // Watchdog: the sequence needs well under 10k cycles
   initial
   begin
      #200000;
      n_fail++;
      summarize();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      c0 = $urandom(32'hae03);
      repeat (6) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      // Reset values plus one unmapped word at 0x18
      for (i = 0; i < 7; i++)
      begin
         rd(5'(i * 4), q);
         chk_reg(q, (i == 1) ? {16'h0, tfm_pkg::CMP_RST, tfm_pkg::CMP_RST} : 32'h0);
      end
      chk_pin(irq, 1'b0);
      wr(tfm_pkg::ADDR_CMP, 32'h1234);
      rd(tfm_pkg::ADDR_CMP, q);
      chk_reg(q, 32'hffff);
      // 16-bit run through the all-ones wrap, clk/4 on both bytes
      power_mode_in <= 3'h0;
      wr(tfm_pkg::ADDR_CTRL, 32'ha4);
      chk_pin(tog_h, 1'b1);
      wr(tfm_pkg::ADDR_CNT, 32'hfffe);
      repeat (40) @(posedge clk_in);
      rd(tfm_pkg::ADDR_STAT, q);
      chk_reg(q, 32'hf);
      chk_pin(tog_h, 1'b0);
      chk_pin(irq, 1'b0);
      wr(tfm_pkg::ADDR_MASK, 32'h1);
      chk_pin(irq, 1'b1);
      wr(tfm_pkg::ADDR_STAT, 32'h1);
      chk_pin(irq, 1'b0);
      rd(tfm_pkg::ADDR_STAT, q);
      chk_reg(q, 32'he);
      // Split mode, random compare bytes, clear on match
      ch = 2 + $urandom % 6;
      cl = 2 + $urandom % 6;
      wr(tfm_pkg::ADDR_CMP, {16'h0, 8'(ch), 8'(cl)});
      wr(tfm_pkg::ADDR_CSR, 32'h3);
      wr(tfm_pkg::ADDR_CTRL, 32'ha1);
      wr(tfm_pkg::ADDR_CNT, 32'h0);
      wr(tfm_pkg::ADDR_STAT, 32'hf);
      // Lower pin is watched only in split mode: unusable in 16-bit
      fh = 0;
      fl = 0;
      ph = tog_h;
      pl = tog_l;
      for (i = 0; i < 480; i++)
      begin
         @(posedge clk_in);
         fh += (tog_h !== ph);
         fl += (tog_l !== pl);
         ph = tog_h;
         pl = tog_l;
      end
      chk_rng(fh, 480 / (4 * (ch + 1)) - 1, 480 / (4 * (ch + 1)) + 1);
      chk_rng(fl, 480 / (4 * (cl + 1)) - 1, 480 / (4 * (cl + 1)) + 1);
      rd(tfm_pkg::ADDR_CNT, q);
      chk_rng(32'(q[15:8]), 0, ch);
      chk_rng(32'(q[7:0]), 0, cl);
      rd(tfm_pkg::ADDR_STAT, q);
      chk_reg(q, 32'h3);
      // Sleep holds registers against writes
      power_mode_in <= 3'h1;
      wr(tfm_pkg::ADDR_CMP, 32'h0);
      rd(tfm_pkg::ADDR_CMP, q);
      chk_reg(q, {16'h0, 8'(ch), 8'(cl)});
      // Watch mode with a system-clock source stays still
      power_mode_in <= 3'h2;
      rd(tfm_pkg::ADDR_CNT, c0);
      repeat (40) @(posedge clk_in);
      rd(tfm_pkg::ADDR_CNT, q);
      chk_reg(q, c0);
      // Software picks subclock/4 before going low power
      power_mode_in <= 3'h0;
      wr(tfm_pkg::ADDR_CSR, 32'h0);
      wr(tfm_pkg::ADDR_CTRL, 32'hf0);
      wr(tfm_pkg::ADDR_CNT, 32'h0);
      power_mode_in <= 3'h2;
      rd(tfm_pkg::ADDR_CNT, c0);
      e0 = n_sub;
      repeat (800) @(posedge clk_in);
      e0 = n_sub - e0;
      rd(tfm_pkg::ADDR_CNT, q);
      chk_rng(32'(q[15:0]) - 32'(c0[15:0]), e0 / 4 - 1, e0 / 4 + 1);
      // Module standby halts the counter
      msb_in <= 1'b1;
      rd(tfm_pkg::ADDR_CNT, c0);
      repeat (100) @(posedge clk_in);
      rd(tfm_pkg::ADDR_CNT, q);
      chk_reg(q, c0);
      summarize();
   end
endmodule : tb_top

//--- tfm_chan.sv
`timescale 1ns/1ps
// ****************************************
// One counter byte with its compare byte
// ****************************************
module tfm_chan #(
   parameter int         W        = 8,
   parameter logic [7:0] CMP_INIT = tfm_pkg::CMP_RST
) (
   input  wire logic         clk_in,
   input  wire logic         srst_in,
   input  wire logic         tick_in,
   input  wire logic         mtick_in,
   input  wire logic         mqual_in,
   input  wire logic         clr_in,
   input  wire logic         cnt_wr_in,
   input  wire logic [W-1:0] cnt_wdata_in,
   input  wire logic         cmp_wr_in,
   input  wire logic [W-1:0] cmp_wdata_in,
   output logic      [W-1:0] cnt_out,
   output logic      [W-1:0] cmp_out,
   output logic              hit_out,
   output logic              match_out,
   output logic              wrap_out
);
   // All state of the byte
   typedef struct packed {
      logic [W-1:0] cnt;   // Counter byte
      logic [W-1:0] cmp;   // Compare byte
   } tfm_chan_st_t;

   tfm_chan_st_t st_q;     // Registered state
   tfm_chan_st_t st_d;     // Next state

   // A compare write replaces the old equality test
   assign hit_out   = cmp_wr_in ? (cmp_wdata_in == st_q.cnt)
                                : (st_q.cmp == st_q.cnt);
   // Match only on the counter clock, leaving the equal value
   assign match_out = mtick_in && mqual_in && hit_out;
   // Software write or clear kills the overflow
   assign wrap_out  = tick_in && (&st_q.cnt) && !clr_in
                      && !cnt_wr_in;
   assign cnt_out   = st_q.cnt;
   assign cmp_out   = st_q.cmp;

   // Next state
   always_comb
   begin
      st_d = st_q;
      if (cnt_wr_in)
         st_d.cnt = cnt_wdata_in;
      else if (clr_in)
         st_d.cnt = '0;
      else if (tick_in)
         st_d.cnt = st_q.cnt + W'(1);
      if (cmp_wr_in)
         st_d.cmp = cmp_wdata_in;
   end

   // State register
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_q.cnt <= W'(tfm_pkg::CNT_RST);
         st_q.cmp <= W'(CMP_INIT);
      end
      else
         st_q <= st_d;
   end

   // ****************************************
   // Checks
   // ****************************************
   a_wrap_to_zero : assert property (@(posedge clk_in) disable iff (srst_in)
      wrap_out |=> (st_q.cnt == '0))
      else $error("Overflow did not leave zero");
   a_match_on_tick : assert property (@(posedge clk_in) disable iff (srst_in)
      match_out |-> mtick_in)
      else $error("Match without counter clock");
   a_clear_zero : assert property (@(posedge clk_in) disable iff (srst_in)
      (clr_in && !cnt_wr_in) |=> (st_q.cnt == '0))
      else $error("Clear did not zero counter");
   a_count_hold : assert property (@(posedge clk_in) disable iff (srst_in)
      (!tick_in && !clr_in && !cnt_wr_in) |=> $stable(st_q.cnt))
      else $error("Counter moved without clock");
endmodule : tfm_chan

//--- tfm_cpu_model.sv
`timescale 1ns/1ps
// ****************************************
// Processor side of the register bus
// ****************************************
module tfm_cpu_model (
   input  wire logic        clk_in,
   input  wire logic        waitrequest_in,
   input  wire logic [31:0] readdata_in,
   output logic      [4:0]  address_out,
   output logic             read_out,
   output logic             write_out,
   output logic      [31:0] writedata_out,
   output logic      [3:0]  byteenable_out
);
   // Idle bus from time zero
   initial
   begin
      address_out    = 5'h1c;
      read_out       = 1'b0;
      write_out      = 1'b0;
      writedata_out  = 32'h0;
      byteenable_out = 4'h0;
   end

   // One transfer; caller enters right after a rising edge
   task automatic xfer(input logic rd, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      address_out    <= a;
      writedata_out  <= d;
      byteenable_out <= 4'h3;
      read_out       <= rd;
      write_out      <= !rd;
      @(posedge clk_in);
      // Hold everything until the slave drops its wait
      while (waitrequest_in !== 1'b0)
         @(posedge clk_in);
      q = readdata_in;
      read_out      <= 1'b0;
      write_out     <= 1'b0;
      // Released lines show junk so a stale value is never trusted
      writedata_out <= ~d;
      address_out   <= ~a;
      @(posedge clk_in);
   endtask : xfer
endmodule : tfm_cpu_model

//--- tfm_pkg.sv
// ****************************************
// Shared constants of the match timer
// ****************************************
package tfm_pkg;
   // Register byte addresses, one word each
   localparam logic [4:0] ADDR_CNT  = 5'h00;
   localparam logic [4:0] ADDR_CMP  = 5'h04;
   localparam logic [4:0] ADDR_CTRL = 5'h08;
   localparam logic [4:0] ADDR_CSR  = 5'h0c;
   localparam logic [4:0] ADDR_STAT = 5'h10;
   localparam logic [4:0] ADDR_MASK = 5'h14;
   // Control register fields
   localparam int CTRL_SPLIT = 0;
   localparam int CTRL_LVL_L = 1;
   localparam int CTRL_LVL_H = 2;
   localparam int CTRL_CKS_L = 4;
   localparam int CTRL_CKS_H = 6;
   // Control/status register fields
   localparam int CSR_CLR_H = 0;
   localparam int CSR_CLR_L = 1;
   // Status and mask bit positions
   localparam int ST_MATCH_H = 0;
   localparam int ST_MATCH_L = 1;
   localparam int ST_WRAP_H  = 2;
   localparam int ST_WRAP_L  = 3;
   // Reset values
   localparam logic [7:0] CNT_RST  = 8'h00;
   localparam logic [7:0] CMP_RST  = 8'hff;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Prescaler terminal counts
   localparam logic [4:0] DIV32_LAST = 5'h1f;
   localparam logic [3:0] DIV16_LAST = 4'hf;
   localparam logic [1:0] DIV4_LAST  = 2'h3;
   localparam logic [1:0] SUB4_LAST  = 2'h3;
   // Counter clock source per byte
   typedef enum logic [1:0] {
      CKS_DIV32 = 2'b00,
      CKS_DIV16 = 2'b01,
      CKS_DIV4  = 2'b10,
      CKS_SUB4  = 2'b11
   } tfm_cks_t;
   // Chip power modes
   typedef enum logic [2:0] {
      PWR_ACTIVE   = 3'b000,
      PWR_SLEEP    = 3'b001,
      PWR_WATCH    = 3'b010,
      PWR_SUBACT   = 3'b011,
      PWR_SUBSLEEP = 3'b100,
      PWR_STANDBY  = 3'b101
   } tfm_pwr_t;
endpackage : tfm_pkg

//--- tfm_top.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Function
// - 16-bit wrap all-ones to zero sets overflow
// - Match signal when counter leaves equal value
// - First equality waits for next counter clock
// - Registers reset; hold in low modes; standby halts
// - Watch, subactive and subsleep count only on subclock/4
// - Subclock/4 resynchronised to system clock
// - Upper toggle flips on full 16-bit match
// - Control write beats match on toggle output
// - Compare write cancels match unless equal
// - Match needs running byte clock
// - 16-bit: upper flag full, lower flag byte
// - 16-bit: both overflow flags set
// - Counter write suppresses coinciding overflow
// - Split mode: each toggle on own match
// - Select bit: 0 16-bit, 1 two bytes
// - Toggle starts at level bit, then inverts
// - Clear enable zeroes counter on match
module tfm_top (
   input  wire logic        clk_in,
   input  wire logic        srst_in,
   input  wire logic [4:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   input  wire logic [3:0]  avs_byteenable_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic        sub_clk_in,
   input  wire logic [2:0]  power_mode_in,
   input  wire logic        module_standby_in,
   output logic             toggle_out_upper_out,
   output logic             toggle_out_lower_out,
   output logic             irq_out
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [4:0]  div;     // System clock prescaler
      logic        s1;      // Subclock sync stage 1
      logic        s2;      // Subclock sync stage 2
      logic        s3;      // Edge detect history
      logic [1:0]  sdiv;    // Subclock divide by 4
      logic [7:0]  ctrl;    // Timer control register
      logic [1:0]  csr;     // Match clear enables
      logic [3:0]  stat;    // Sticky event flags
      logic [3:0]  mask;    // Interrupt mask
      logic        tog_h;   // Upper toggle pin
      logic        tog_l;   // Lower toggle pin
      logic        irq;     // Interrupt level
      logic        wait_r;  // Bus wait request
      logic [31:0] rdata;   // Bus read data
   } tfm_top_st_t;

   tfm_top_st_t st_q;       // Registered state
   tfm_top_st_t st_d;       // Next state

   // ****************************************
   // Power mode decode
   // ****************************************
   tfm_pkg::tfm_pwr_t pwr;  // Current chip mode
   logic sys_run;           // System clock sources alive
   logic sub_run;           // Subclock source alive
   logic reg_run;           // Registers accept writes

   assign pwr     = tfm_pkg::tfm_pwr_t'(power_mode_in);
   // Prescaled system clocks only exist while the CPU clock runs
   assign sys_run = (pwr == tfm_pkg::PWR_ACTIVE)
                    || (pwr == tfm_pkg::PWR_SLEEP);
   // Standby and module standby stop every source
   assign sub_run = !module_standby_in
                    && ((pwr == tfm_pkg::PWR_ACTIVE)
                    || (pwr == tfm_pkg::PWR_SLEEP)
                    || (pwr == tfm_pkg::PWR_WATCH)
                    || (pwr == tfm_pkg::PWR_SUBACT)
                    || (pwr == tfm_pkg::PWR_SUBSLEEP));
   // Registers function in active and subactive only
   assign reg_run = !module_standby_in
                    && ((pwr == tfm_pkg::PWR_ACTIVE)
                    || (pwr == tfm_pkg::PWR_SUBACT));

   // ****************************************
   // Counter clock sources
   // ****************************************
   logic       sub_edge;    // Rising subclock edge
   logic [3:0] tvec;        // Ticks indexed by source
   logic       tick_l;      // Lower byte clock
   logic       tick_h;      // Upper byte clock (split)
   logic       split;       // Two 8-bit counters

   // Edge is taken from the settled stages only
   assign sub_edge = st_q.s2 && !st_q.s3;
   assign tvec[tfm_pkg::CKS_DIV32] = sys_run && !module_standby_in
                                     && (st_q.div == tfm_pkg::DIV32_LAST);
   assign tvec[tfm_pkg::CKS_DIV16] = sys_run && !module_standby_in
                                     && (st_q.div[3:0] == tfm_pkg::DIV16_LAST);
   assign tvec[tfm_pkg::CKS_DIV4]  = sys_run && !module_standby_in
                                     && (st_q.div[1:0] == tfm_pkg::DIV4_LAST);
   // Only this source survives watch, subactive and subsleep
   assign tvec[tfm_pkg::CKS_SUB4]  = sub_run && sub_edge
                                     && (st_q.sdiv == tfm_pkg::SUB4_LAST);
   assign tick_l = tvec[st_q.ctrl[tfm_pkg::CTRL_CKS_L +: 2]];
   assign tick_h = tvec[st_q.ctrl[tfm_pkg::CTRL_CKS_H +: 2]];
   assign split  = st_q.ctrl[tfm_pkg::CTRL_SPLIT];

   // ****************************************
   // Bus decode
   // ****************************************
   logic take;              // Request completes this edge
   logic wr;                // Write takes effect
   logic cnt_wr_l;          // Lower counter byte write
   logic cnt_wr_h;          // Upper counter byte write
   logic cmp_wr_l;          // Lower compare byte write
   logic cmp_wr_h;          // Upper compare byte write
   logic ctrl_wr;           // Control register write
   logic csr_wr;            // Clear enable write
   logic stat_wr;           // Flag clear write
   logic mask_wr;           // Mask write

   // Effect lands on the edge where wait is seen low
   assign take     = (avs_read_in || avs_write_in) && !st_q.wait_r;
   // Writes in halted modes are dropped, registers hold
   assign wr       = take && avs_write_in && reg_run;
   assign cnt_wr_l = wr && (avs_address_in == tfm_pkg::ADDR_CNT)
                     && avs_byteenable_in[0];
   assign cnt_wr_h = wr && (avs_address_in == tfm_pkg::ADDR_CNT)
                     && avs_byteenable_in[1];
   assign cmp_wr_l = wr && (avs_address_in == tfm_pkg::ADDR_CMP)
                     && avs_byteenable_in[0];
   assign cmp_wr_h = wr && (avs_address_in == tfm_pkg::ADDR_CMP)
                     && avs_byteenable_in[1];
   assign ctrl_wr  = wr && (avs_address_in == tfm_pkg::ADDR_CTRL)
                     && avs_byteenable_in[0];
   assign csr_wr   = wr && (avs_address_in == tfm_pkg::ADDR_CSR)
                     && avs_byteenable_in[0];
   assign stat_wr  = wr && (avs_address_in == tfm_pkg::ADDR_STAT)
                     && avs_byteenable_in[0];
   assign mask_wr  = wr && (avs_address_in == tfm_pkg::ADDR_MASK)
                     && avs_byteenable_in[0];

   // ****************************************
   // Counter bytes
   // ****************************************
   logic [7:0] cnt_l;       // Lower counter byte
   logic [7:0] cnt_h;       // Upper counter byte
   logic [7:0] cmp_l;       // Lower compare byte
   logic [7:0] cmp_h;       // Upper compare byte
   logic       hit_l;       // Lower equality term
   logic       m_l;         // Lower match signal
   logic       m_h;         // Upper or 16-bit match
   logic       wrap_l;      // Lower overflow, also carry
   logic       wrap_h;      // Upper or 16-bit overflow
   logic       clr_l;       // Lower clear on match
   logic       clr_h;       // Upper clear on match
   logic       tk_h;        // Upper counting clock
   logic       mtk_h;       // Upper match clock
   logic       mq_h;        // Upper match qualifier

   // Joined mode: upper counts on lower carry
   assign tk_h  = split ? tick_h : wrap_l;
   // Joined mode: full match is judged on the lower clock
   assign mtk_h = split ? tick_h : tick_l;
   assign mq_h  = split || hit_l;
   // Joined mode clears all 16 bits on the full match
   assign clr_l = split ? (m_l && st_q.csr[tfm_pkg::CSR_CLR_L])
                        : (m_h && st_q.csr[tfm_pkg::CSR_CLR_H]);
   assign clr_h = m_h && st_q.csr[tfm_pkg::CSR_CLR_H];

   tfm_chan #(
      .W        (8),
      .CMP_INIT (tfm_pkg::CMP_RST)
   ) u_lower (
      .clk_in       (clk_in),
      .srst_in      (srst_in),
      .tick_in      (tick_l),
      .mtick_in     (tick_l),
      .mqual_in     (1'b1),
      .clr_in       (clr_l),
      .cnt_wr_in    (cnt_wr_l),
      .cnt_wdata_in (avs_writedata_in[7:0]),
      .cmp_wr_in    (cmp_wr_l),
      .cmp_wdata_in (avs_writedata_in[7:0]),
      .cnt_out      (cnt_l),
      .cmp_out      (cmp_l),
      .hit_out      (hit_l),
      .match_out    (m_l),
      .wrap_out     (wrap_l)
   );

   tfm_chan #(
      .W        (8),
      .CMP_INIT (tfm_pkg::CMP_RST)
   ) u_upper (
      .clk_in       (clk_in),
      .srst_in      (srst_in),
      .tick_in      (tk_h),
      .mtick_in     (mtk_h),
      .mqual_in     (mq_h),
      .clr_in       (clr_h),
      .cnt_wr_in    (cnt_wr_h),
      .cnt_wdata_in (avs_writedata_in[15:8]),
      .cmp_wr_in    (cmp_wr_h),
      .cmp_wdata_in (avs_writedata_in[15:8]),
      .cnt_out      (cnt_h),
      .cmp_out      (cmp_h),
      .hit_out      (),
      .match_out    (m_h),
      .wrap_out     (wrap_h)
   );

   // ****************************************
   // Next state
   // ****************************************
   logic [3:0] ev;          // Event pulses, status layout
   logic [3:0] w1c;         // Flags cleared by software

   assign ev[tfm_pkg::ST_MATCH_H] = m_h;
   assign ev[tfm_pkg::ST_MATCH_L] = m_l;
   assign ev[tfm_pkg::ST_WRAP_H]  = wrap_h;
   assign ev[tfm_pkg::ST_WRAP_L]  = wrap_l;
   assign w1c = stat_wr ? avs_writedata_in[3:0] : 4'h0;

   always_comb
   begin
      st_d        = st_q;
      // Free running prescaler and subclock path
      st_d.div    = st_q.div + 5'h01;
      st_d.s1     = sub_clk_in;
      st_d.s2     = st_q.s1;
      st_d.s3     = st_q.s2;
      if (sub_edge && sub_run)
         st_d.sdiv = st_q.sdiv + 2'h1;
      // Software owned configuration
      if (ctrl_wr)
         st_d.ctrl = avs_writedata_in[7:0];
      if (csr_wr)
         st_d.csr = avs_writedata_in[1:0];
      if (mask_wr)
         st_d.mask = avs_writedata_in[3:0];
      // A new event wins over a clear in the same cycle
      st_d.stat   = (st_q.stat & ~w1c) | ev;
      // Written level wins over a coinciding match
      if (ctrl_wr)
         st_d.tog_h = avs_writedata_in[tfm_pkg::CTRL_LVL_H];
      else if (m_h)
         st_d.tog_h = !st_q.tog_h;
      // Lower pin still toggles in joined mode, unused there
      if (ctrl_wr)
         st_d.tog_l = avs_writedata_in[tfm_pkg::CTRL_LVL_L];
      else if (m_l)
         st_d.tog_l = !st_q.tog_l;
      st_d.irq    = |(st_d.stat & st_d.mask);
      // One wait-low cycle per request
      st_d.wait_r = !((avs_read_in || avs_write_in) && st_q.wait_r);
      // Read data is formed one edge early to stand with wait low
      st_d.rdata  = 32'h0000_0000;
      if (avs_read_in && st_q.wait_r)
      begin
         case (avs_address_in)
            tfm_pkg::ADDR_CNT:  st_d.rdata = {16'h0000, cnt_h, cnt_l};
            tfm_pkg::ADDR_CMP:  st_d.rdata = {16'h0000, cmp_h, cmp_l};
            tfm_pkg::ADDR_CTRL: st_d.rdata = {24'h00_0000, st_q.ctrl};
            tfm_pkg::ADDR_CSR:  st_d.rdata = {30'h0000_0000, st_q.csr};
            tfm_pkg::ADDR_STAT: st_d.rdata = {28'h000_0000, st_q.stat};
            tfm_pkg::ADDR_MASK: st_d.rdata = {28'h000_0000, st_q.mask};
            default:            st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         st_q        <= '0;
         st_q.ctrl   <= tfm_pkg::CTRL_RST;
         st_q.wait_r <= 1'b1;
      end
      else
         st_q <= st_d;
   end

   assign avs_readdata_out     = st_q.rdata;
   assign avs_waitrequest_out  = st_q.wait_r;
   assign toggle_out_upper_out = st_q.tog_h;
   assign toggle_out_lower_out = st_q.tog_l;
   assign irq_out              = st_q.irq;

   // ****************************************
   // Checks
   // ****************************************
   a_carry_only_full : assert property (@(posedge clk_in) disable iff (srst_in)
      (!split && tk_h) |-> (cnt_l == 8'hff && tick_l))
      else $error("Upper byte counted without carry");
   a_wrap16_zero : assert property (@(posedge clk_in) disable iff (srst_in)
      (!split && wrap_h && !ctrl_wr) |=> ({cnt_h, cnt_l} == 16'h0000)
      && st_q.stat[tfm_pkg::ST_WRAP_H])
      else $error("16-bit wrap not flagged at zero");
   a_full_match : assert property (@(posedge clk_in) disable iff (srst_in)
      (!split && m_h && !ctrl_wr) |=> (st_q.tog_h != $past(st_q.tog_h)))
      else $error("Upper toggle missed full match");
   a_write_level : assert property (@(posedge clk_in) disable iff (srst_in)
      ctrl_wr |=> (st_q.tog_l == st_q.ctrl[tfm_pkg::CTRL_LVL_L])
      && (st_q.tog_h == st_q.ctrl[tfm_pkg::CTRL_LVL_H]))
      else $error("Toggle pin not at written level");
   a_low_power_src : assert property (@(posedge clk_in) disable iff (srst_in)
      (pwr == tfm_pkg::PWR_WATCH
      && st_q.ctrl[tfm_pkg::CTRL_CKS_L +: 2] != tfm_pkg::CKS_SUB4) |-> !tick_l)
      else $error("Counter ran on system source in watch");
   a_standby_halt : assert property (@(posedge clk_in) disable iff (srst_in)
      (pwr == tfm_pkg::PWR_STANDBY || module_standby_in) |-> (tvec == 4'h0))
      else $error("Counter clock alive in standby");
   a_flag_sticky : assert property (@(posedge clk_in) disable iff (srst_in)
      (st_q.stat[tfm_pkg::ST_MATCH_L] && !w1c[tfm_pkg::ST_MATCH_L])
      |=> st_q.stat[tfm_pkg::ST_MATCH_L])
      else $error("Match flag lost without clear");
   a_cmp_cancel : assert property (@(posedge clk_in) disable iff (srst_in)
      (cmp_wr_l && (avs_writedata_in[7:0] != cnt_l)) |-> !m_l)
      else $error("Compare write did not cancel match");
   a_wait_single : assert property (@(posedge clk_in) disable iff (srst_in)
      !st_q.wait_r |=> st_q.wait_r)
      else $error("Wait low for two cycles");
   // The lower split channel toggles on its own match; a control write
   // in the same cycle takes the pin instead, so it is excluded here
   a_split_own_match : assert property (@(posedge clk_in) disable iff (srst_in)
      (split && m_l && !ctrl_wr) |=> (st_q.tog_l != $past(st_q.tog_l)))
      else $error("Lower toggle missed own match");
   a_lower_flag16 : assert property (@(posedge clk_in) disable iff (srst_in)
      (!split && m_l) |=> st_q.stat[tfm_pkg::ST_MATCH_L])
      else $error("Lower match flag not set");
   a_write_no_wrap : assert property (@(posedge clk_in) disable iff (srst_in)
      (cnt_wr_l && !st_q.stat[tfm_pkg::ST_WRAP_L]) |=> !st_q.stat[tfm_pkg::ST_WRAP_L])
      else $error("Overflow flagged on counter write");
   a_hold_low_power : assert property (@(posedge clk_in) disable iff (srst_in)
      !reg_run |=> ($stable(st_q.ctrl) && $stable(st_q.csr) && $stable(cmp_l)
      && $stable(cmp_h)))
      else $error("Register changed while held");
   a_full_on_tick : assert property (@(posedge clk_in) disable iff (srst_in)
      (!split && m_h && !cmp_wr_l) |-> (tick_l && (cnt_l == cmp_l)))
      else $error("Full match off the lower clock");
endmodule : tfm_top
